// ---- common/sqs_params.svh ----
//----------------------------------------------------------------------
// constants for the queue / sniff / port-three control bank
//----------------------------------------------------------------------
// holds register offsets, bit positions, reset values and weights.
// assumes it is included by bare name from rtl and testbench files.
`ifndef SQS_PARAMS_SVH
`define SQS_PARAMS_SVH

// register offsets on the host register port
`define SQS_ADDR_GC3      8'h05
`define SQS_ADDR_GC4      8'h06

// bit positions inside the control registers
`define SQS_BIT_WFQ       3
`define SQS_BIT_SNIFF     0
`define SQS_BIT_DUPLEX    6
`define SQS_BIT_FLOWC     5

// reserved bits that read zero and drop writes
`define SQS_BIT_RSV3_4    4
`define SQS_BIT_RSV3_2    2
`define SQS_BIT_RSV3_1    1
`define SQS_BIT_RSV4_7    7

// reset values before the strap levels are loaded
`define SQS_RST_WFQ       1'h0
`define SQS_RST_SNIFF     1'h0
`define SQS_RST_DUPLEX    1'h0
`define SQS_RST_FLOWC     1'h1
`define SQS_RST_BYTE      8'h00

// base weights of queues three down to zero
`define SQS_W_Q3          4'h8
`define SQS_W_Q2          4'h4
`define SQS_W_Q1          4'h2
`define SQS_W_Q0          4'h1
`define SQS_W_NONE        4'h0

`endif

// ---- common/sqs_pkg.sv ----
//----------------------------------------------------------------------
// shared types for the queue / sniff / port-three control bank
//----------------------------------------------------------------------
// holds the data types used by the rtl files.
// assumes sqs_params.svh is on the include path.
package sqs_pkg;
    typedef logic [7:0]  sqs_byte_t;     // one register byte
    typedef logic [3:0]  sqs_weight_t;   // weight of one queue
    typedef logic [15:0] sqs_wvec_t;     // weights of q3..q0, q0 lowest
endpackage : sqs_pkg

// ---- rtl/sqs_ctrl.sv ----
//----------------------------------------------------------------------
// queue scheduling, sniff mode and port-three mii control bank
//----------------------------------------------------------------------
// holds two control registers, strap capture and the steered outputs.
// assumes a synchronous register port and synchronous strap levels.
//
// Summary of operation
// - wfq off: per-port priority method steers scheduling
// - wfq on, all busy: weights 8:4:2:1
// - empty queue weight zero, top busy gains one per empty queue
// - sniff bit one: source and destination must match
// - sniff bit zero: source or destination matches
// - duplex bit one half duplex, zero full
// - duplex reset value taken from duplex strap pin
// - flow-control bit enables port-three flow control
// - flow-control reset value taken from flow strap pin
`timescale 1ns/1ns
`include "sqs_params.svh"

module sqs_ctrl
    import sqs_pkg::*;
(
    input  wire logic       clock_i,             // 20 MHz core clock
    input  wire logic       rst_n_i,             // async reset, active low
    input  wire logic [7:0] reg_addr_i,          // register offset
    input  wire logic [7:0] reg_wdata_i,         // write data
    input  wire logic       reg_wr_i,            // write strobe, one cycle
    input  wire logic       reg_rd_i,            // read strobe, one cycle
    output sqs_byte_t       reg_rdata_o,         // read data, next cycle
    output logic            reg_rvalid_o,        // read data valid pulse
    input  wire logic       duplex_strap_pin,    // strap for half duplex
    input  wire logic       flow_ctrl_strap_pin, // strap for flow control
    input  wire logic [3:0] q_nonempty_i,        // egress queue busy flags
    input  wire logic [2:0] port_prio_mode_i,    // per-port method, ports 3..1
    output logic            wfq_active_o,        // wfq scheduling in force
    output sqs_wvec_t       q_weight_o,          // wfq weights q3..q0
    output logic [2:0]      port_prio_mode_o,    // per-port method in force
    input  wire logic       src_match_i,         // source port is sniffed
    input  wire logic       dst_match_i,         // destination port sniffed
    output logic            mirror_o,            // mirror this packet
    output logic            p3_half_duplex_o,    // port three half duplex
    output logic            p3_flow_ctrl_o       // port three flow control
);

    //------------------------------------------------------------------
    // register port decode
    //------------------------------------------------------------------

    // true when a strobe addresses the given offset
    function automatic logic hit(input logic       stb,
                                 input logic [7:0] addr,
                                 input logic [7:0] target);
        hit = stb && (addr == target);
    endfunction : hit

    logic wr_gc3;
    logic wr_gc4;
    logic strap_done_q;                           // straps loaded after reset

    // writes are held off until the straps are loaded
    assign wr_gc3 = hit(reg_wr_i, reg_addr_i, `SQS_ADDR_GC3) && strap_done_q;
    assign wr_gc4 = hit(reg_wr_i, reg_addr_i, `SQS_ADDR_GC4) && strap_done_q;

    //------------------------------------------------------------------
    // strap capture
    //------------------------------------------------------------------

    logic strap_done_d;
    logic dup_smp_q;
    logic dup_smp_d;
    logic fc_smp_q;
    logic fc_smp_d;

    // follow the straps until loaded, then freeze the sampled levels
    always_comb begin
        dup_smp_d = dup_smp_q;
        fc_smp_d  = fc_smp_q;
        if (!strap_done_q) begin
            dup_smp_d = duplex_strap_pin;
            fc_smp_d  = flow_ctrl_strap_pin;
        end
    end

    // sampled strap levels; no reset so that reset itself samples them
    always_ff @(posedge clock_i) begin
        dup_smp_q <= dup_smp_d;
        fc_smp_q  <= fc_smp_d;
    end

    // load flag set on the first edge after reset release
    always_comb begin
        strap_done_d = 1'h1;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            strap_done_q <= 1'h0;
        end else begin
            strap_done_q <= strap_done_d;
        end
    end

    //------------------------------------------------------------------
    // control registers
    //------------------------------------------------------------------

    logic wfq_q,   wfq_d;
    logic sniff_q, sniff_d;
    logic dup_q,   dup_d;
    logic fc_q,    fc_d;

    // next values: strap load first, then software writes
    always_comb begin
        wfq_d   = wfq_q;
        sniff_d = sniff_q;
        dup_d   = dup_q;
        fc_d    = fc_q;
        if (!strap_done_q) begin
            dup_d = dup_smp_q;
            fc_d  = fc_smp_q;
        end
        if (wr_gc3) begin
            wfq_d   = reg_wdata_i[`SQS_BIT_WFQ];  // bits 4,2,1 dropped
            sniff_d = reg_wdata_i[`SQS_BIT_SNIFF];
        end
        if (wr_gc4) begin
            dup_d = reg_wdata_i[`SQS_BIT_DUPLEX]; // bit 7 dropped
            fc_d  = reg_wdata_i[`SQS_BIT_FLOWC];
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wfq_q   <= `SQS_RST_WFQ;
            sniff_q <= `SQS_RST_SNIFF;
            dup_q   <= `SQS_RST_DUPLEX;
            fc_q    <= `SQS_RST_FLOWC;
        end else begin
            wfq_q   <= wfq_d;
            sniff_q <= sniff_d;
            dup_q   <= dup_d;
            fc_q    <= fc_d;
        end
    end

    // port-three mii settings straight from the registers
    assign p3_half_duplex_o = dup_q;
    assign p3_flow_ctrl_o   = fc_q;

    //------------------------------------------------------------------
    // read path
    //------------------------------------------------------------------

    sqs_byte_t rdata_d;
    logic      rvalid_d;

    // reserved and foreign bits read as zero
    always_comb begin
        rvalid_d = reg_rd_i;
        rdata_d  = `SQS_RST_BYTE;
        if (hit(reg_rd_i, reg_addr_i, `SQS_ADDR_GC3)) begin
            rdata_d[`SQS_BIT_WFQ]   = wfq_q;
            rdata_d[`SQS_BIT_SNIFF] = sniff_q;
        end else if (hit(reg_rd_i, reg_addr_i, `SQS_ADDR_GC4)) begin
            rdata_d[`SQS_BIT_DUPLEX] = dup_q;
            rdata_d[`SQS_BIT_FLOWC]  = fc_q;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o  <= `SQS_RST_BYTE;
            reg_rvalid_o <= 1'h0;
        end else begin
            reg_rdata_o  <= rdata_d;
            reg_rvalid_o <= rvalid_d;
        end
    end

    //------------------------------------------------------------------
    // scheduling and mirroring
    //------------------------------------------------------------------

    sqs_wvec_t  wfq_w;
    sqs_wvec_t  weight_d;
    logic [2:0] prio_d;
    logic       mirror_d;

    sqs_wfq_weights u_weights (
        .nonempty_i (q_nonempty_i),
        .weight_o   (wfq_w)
    );

    // pick wfq weights or per-port method, and the sniff match
    always_comb begin
        weight_d = wfq_q ? wfq_w : '0;
        prio_d   = wfq_q ? 3'h0 : port_prio_mode_i;
        if (sniff_q) begin
            mirror_d = src_match_i && dst_match_i;
        end else begin
            mirror_d = src_match_i || dst_match_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_weight_o       <= '0;
            port_prio_mode_o <= 3'h0;
            wfq_active_o     <= 1'h0;
            mirror_o         <= 1'h0;
        end else begin
            q_weight_o       <= weight_d;
            port_prio_mode_o <= prio_d;
            wfq_active_o     <= wfq_q;
            mirror_o         <= mirror_d;
        end
    end

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_wr_gc4;
        reg_wr_i && (reg_addr_i == `SQS_ADDR_GC4) && strap_done_q;
    endsequence

    sequence s_rd_gc3;
        reg_rd_i && (reg_addr_i == `SQS_ADDR_GC3);
    endsequence

    sequence s_rd_gc4;
        reg_rd_i && (reg_addr_i == `SQS_ADDR_GC4);
    endsequence

    chk_prio_pass_through: assert property (
        !wfq_q |=> (port_prio_mode_o == $past(port_prio_mode_i)) && (q_weight_o == '0))
        else $error("per-port method not passed with wfq off");

    chk_wfq_full_ratio: assert property (
        wfq_q && (q_nonempty_i == 4'hF) |=> (q_weight_o == 16'h8421))
        else $error("wfq weights not 8:4:2:1 with all queues busy");

    chk_wfq_empty_q2: assert property (
        wfq_q && (q_nonempty_i == 4'hB) |=> (q_weight_o == 16'h9021))
        else $error("empty queue weight not moved to top busy queue");

    chk_mirror_and_mode: assert property (
        sniff_q && (src_match_i != dst_match_i) |=> !mirror_o)
        else $error("mirrored on one match in and mode");

    chk_mirror_or_mode: assert property (
        !sniff_q && (src_match_i || dst_match_i) |=> mirror_o)
        else $error("missed mirror in or mode");

    chk_duplex_write: assert property (
        s_wr_gc4 |=> (p3_half_duplex_o == $past(reg_wdata_i[`SQS_BIT_DUPLEX]))
                  && (p3_flow_ctrl_o == $past(reg_wdata_i[`SQS_BIT_FLOWC])))
        else $error("port three settings not written");

    chk_strap_load: assert property (
        $rose(strap_done_q) |-> (p3_half_duplex_o == $past(dup_smp_q))
                             && (p3_flow_ctrl_o == $past(fc_smp_q)))
        else $error("strap levels not loaded at reset release");

    chk_reserved_zero: assert property (
        s_rd_gc3 |=> reg_rvalid_o && (reg_rdata_o[`SQS_BIT_RSV3_4] == 1'h0)
                  && (reg_rdata_o[`SQS_BIT_RSV3_2] == 1'h0)
                  && (reg_rdata_o[`SQS_BIT_RSV3_1] == 1'h0))
        else $error("reserved bits read nonzero");

    chk_reserved_gc4: assert property (
        s_rd_gc4 |=> reg_rvalid_o && (reg_rdata_o[`SQS_BIT_RSV4_7] == 1'h0))
        else $error("reserved bit of control four read nonzero");

endmodule : sqs_ctrl

// ---- rtl/sqs_wfq_weights.sv ----
//----------------------------------------------------------------------
// weighted fair queuing weight calculator
//----------------------------------------------------------------------
// holds the combinational weight table for four egress queues.
// assumes the caller registers the result.
`timescale 1ns/1ns
`include "sqs_params.svh"

module sqs_wfq_weights
    import sqs_pkg::*;
(
    input  wire logic [3:0] nonempty_i,  // queue holds packets, bit n = qn
    output sqs_wvec_t       weight_o     // weights, 4 bits per queue
);

    // base weight of one queue
    function automatic sqs_weight_t base_w(input int unsigned q);
        case (q)
            3:       base_w = `SQS_W_Q3;
            2:       base_w = `SQS_W_Q2;
            1:       base_w = `SQS_W_Q1;
            default: base_w = `SQS_W_Q0;
        endcase
    endfunction : base_w

    // empty queues get nothing, highest busy queue gains one per empty one
    always_comb begin
        sqs_weight_t extra;
        int          top;
        extra    = `SQS_W_NONE;
        top      = -1;
        weight_o = '0;
        for (int q = 0; q < 4; q++) begin
            if (nonempty_i[q]) begin
                top = q;
                weight_o[q*4 +: 4] = base_w(q);
            end else begin
                extra = extra + 4'h1;
            end
        end
        if (top >= 0) begin
            weight_o[top*4 +: 4] = weight_o[top*4 +: 4] + extra;
        end
    end

endmodule : sqs_wfq_weights

// ---- tb/tb.sv ----
//----------------------------------------------------------------------
// self-checking testbench for the queue / sniff / port-three bank
//----------------------------------------------------------------------
// holds the clock, reset, register tasks and one task per scenario.
// assumes sqs_pkg is compiled first and sqs_params.svh is on the path.
`timescale 1ns/1ns
`include "sqs_params.svh"

module tb
    import sqs_pkg::*;
;
    logic       clock_i;
    logic       rst_n_i;
    logic [7:0] reg_addr_i;
    logic [7:0] reg_wdata_i;
    logic       reg_wr_i;
    logic       reg_rd_i;
    sqs_byte_t  reg_rdata_o;
    logic       reg_rvalid_o;
    logic       duplex_strap_pin;
    logic       flow_ctrl_strap_pin;
    logic [3:0] q_nonempty_i;
    logic [2:0] port_prio_mode_i;
    logic       wfq_active_o;
    sqs_wvec_t  q_weight_o;
    logic [2:0] port_prio_mode_o;
    logic       src_match_i;
    logic       dst_match_i;
    logic       mirror_o;
    logic       p3_half_duplex_o;
    logic       p3_flow_ctrl_o;
    int         n_mismatch;
    int         checks;

    sqs_ctrl u_sqs_ctrl (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .duplex_strap_pin(duplex_strap_pin), .flow_ctrl_strap_pin(flow_ctrl_strap_pin),
        .q_nonempty_i(q_nonempty_i), .port_prio_mode_i(port_prio_mode_i),
        .wfq_active_o(wfq_active_o), .q_weight_o(q_weight_o),
        .port_prio_mode_o(port_prio_mode_o), .src_match_i(src_match_i),
        .dst_match_i(dst_match_i), .mirror_o(mirror_o),
        .p3_half_duplex_o(p3_half_duplex_o), .p3_flow_ctrl_o(p3_flow_ctrl_o)
    );

    //------------------------------------------------------------------
    // shared tasks
    //------------------------------------------------------------------
    // 20 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    // compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // verdict and end of run
    task automatic complete_run();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    // let the edge after the drive sample, then look at the outputs
    task automatic settle();
        @(posedge clock_i);
        @(negedge clock_i);
    endtask : settle

    // one-cycle write strobe
    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= addr;
        reg_wdata_i <= data;
        @(posedge clock_i);
        reg_wr_i    <= 1'b0;
        reg_wdata_i <= ~data;
    endtask : reg_write

    // one-cycle read strobe, data checked in the answer cycle
    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clock_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= addr;
        @(posedge clock_i);
        reg_rd_i   <= 1'b0;
        @(negedge clock_i);
        check({15'h0000, reg_rvalid_o}, 16'h0001);
        check({8'h00, reg_rdata_o}, {8'h00, exp});
    endtask : reg_read

    // expected wfq weights for a busy pattern
    function automatic logic [15:0] exp_w(input logic [3:0] ne);
        int         top;
        int         empt;
        logic [3:0] w;
        logic [15:0] r;
        top  = -1;
        empt = 0;
        r    = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            if (ne[i]) top = i; else empt++;
        end
        for (int i = 0; i < 4; i++) begin
            w = ne[i] ? 4'(1 << i) : 4'h0;
            if (i == top) w = w + 4'(empt);
            r[i*4 +: 4] = w;
        end
        return r;
    endfunction : exp_w

    //------------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------------
    // reset with given straps, outputs checked inside and after reset
    task automatic t_reset(input logic dup, input logic flw);
        @(posedge clock_i);
        rst_n_i             <= 1'b0;
        duplex_strap_pin    <= dup;
        flow_ctrl_strap_pin <= flw;
        repeat (20) @(posedge clock_i);
        check({14'h0000, p3_half_duplex_o, p3_flow_ctrl_o}, 16'h0001);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        check({15'h0000, p3_half_duplex_o}, {15'h0000, dup});
        check({15'h0000, p3_flow_ctrl_o}, {15'h0000, flw});
    endtask : t_reset

    // reserved bits, unmapped offset, duplex and flow bits
    task automatic t_regs();
        reg_write(8'h05, 8'hFF);
        reg_read(8'h05, 8'h09);
        reg_write(8'h06, 8'hFF);
        reg_read(8'h06, 8'h60);
        check({14'h0000, p3_half_duplex_o, p3_flow_ctrl_o}, 16'h0003);
        reg_write(8'h06, 8'h00);
        @(negedge clock_i);
        check({14'h0000, p3_half_duplex_o, p3_flow_ctrl_o}, 16'h0000);
        reg_write(8'h07, 8'hFF);
        reg_read(8'h07, 8'h00);
        reg_write(8'h06, 8'h40);
        reg_read(8'h06, 8'h40);
    endtask : t_regs

    // every busy pattern under wfq, then priority method with wfq off
    task automatic t_wfq();
        reg_write(8'h05, 8'h08);
        port_prio_mode_i <= 3'h5;
        for (int m = 0; m < 16; m++) begin
            @(posedge clock_i);
            q_nonempty_i <= 4'(m);
            settle();
            check(q_weight_o, exp_w(4'(m)));
            check({12'h000, wfq_active_o, port_prio_mode_o}, 16'h0008);
        end
        reg_write(8'h05, 8'h00);
        settle();
        check(q_weight_o, 16'h0000);
        check({12'h000, wfq_active_o, port_prio_mode_o}, 16'h0005);
    endtask : t_wfq

    // both sniff modes over all match combinations
    task automatic t_mirror();
        for (int md = 0; md < 2; md++) begin
            reg_write(8'h05, 8'(md));
            for (int k = 0; k < 4; k++) begin
                @(posedge clock_i);
                src_match_i <= k[1];
                dst_match_i <= k[0];
                settle();
                check({15'h0000, mirror_o},
                      {15'h0000, (md == 1) ? &k[1:0] : |k[1:0]});
            end
        end
    endtask : t_mirror

    //------------------------------------------------------------------
    // main sequence and watchdog
    //------------------------------------------------------------------
    // drives every input at time zero, then runs the scenarios
    initial begin
        n_mismatch          = 0;
        checks              = 0;
        rst_n_i             = 1'b0;
        reg_addr_i          = 8'h00;
        reg_wdata_i         = 8'h00;
        reg_wr_i            = 1'b0;
        reg_rd_i            = 1'b0;
        duplex_strap_pin    = 1'b0;
        flow_ctrl_strap_pin = 1'b1;
        q_nonempty_i        = 4'h0;
        port_prio_mode_i    = 3'h0;
        src_match_i         = 1'b0;
        dst_match_i         = 1'b0;
        t_reset(1'b1, 1'b0);
        t_regs();
        t_wfq();
        t_mirror();
        t_reset(1'b0, 1'b1);
        complete_run();
    end

    // cuts a hang short well past the expected run length
    initial begin
        repeat (5000) @(posedge clock_i);
        n_mismatch++;
        complete_run();
    end
endmodule : tb
